//--- design/latch_family_pkg.sv
// shared types and constants for the transparent latch family
package latch_family_pkg;

  // ==========================================================
  // widths and values after reset and preset
  // ==========================================================
  localparam int unsigned NARROW_WIDTH = 4;
  localparam int unsigned MID_WIDTH = 8;
  localparam int unsigned WIDE_WIDTH = 16;
  localparam logic LATCH_RESET_VALUE = 1'h0;
  localparam logic LATCH_PRESET_VALUE = 1'h1;

  // ==========================================================
  // control bundle of one latch
  // ==========================================================
  typedef struct packed {
    logic gate;
    logic enable;
    logic force_low;
    logic preset;
  } latch_ctrl_t;

endpackage

//--- design/latch_family.sv
// transparent latch family: single and multi-bit level latches
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// one latch cell of any width and gate sense
// ==========================================================
// level behaviour on a single clock: the stored copy follows data while
// open, so the output is a mux of live data and the copy. trade-off: the
// closing edge is resolved to one mclk cycle, not to a set-up time.
module latch_cell #(
  parameter int unsigned WIDTH = 1,
  parameter bit INV_GATE = 1'b0
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // control
  input wire logic chip_wide_clear_i,
  input wire latch_family_pkg::latch_ctrl_t ctrl_i,
  // data
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  import latch_family_pkg::*;

  logic [WIDTH-1:0] hold_q;
  logic clr;
  logic open_gate;

  // reset, common clear and local clear share one path
  assign clr = srst_i | chip_wide_clear_i | ctrl_i.force_low;
  // gate sense, then enable, then both overrides
  assign open_gate = (ctrl_i.gate ^ INV_GATE) & ctrl_i.enable
                     & ~clr & ~ctrl_i.preset;

  // ==========================================================
  // stored copy
  // ==========================================================
  always_ff @(posedge mclk_i) begin
    if (clr) begin
      hold_q <= {WIDTH{LATCH_RESET_VALUE}};
    end else if (ctrl_i.preset) begin
      hold_q <= {WIDTH{LATCH_PRESET_VALUE}};
    end else if (open_gate) begin
      hold_q <= d_i;
    end
  end

  // overrides act at once, without waiting for a clock edge
  always_comb begin
    if (clr) begin
      q_o = {WIDTH{LATCH_RESET_VALUE}};
    end else if (ctrl_i.preset) begin
      q_o = {WIDTH{LATCH_PRESET_VALUE}};
    end else if (open_gate) begin
      q_o = d_i;
    end else begin
      q_o = hold_q;
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  clear_forces_low_a: assert property (@(posedge mclk_i)
    srst_i || chip_wide_clear_i || ctrl_i.force_low
    |-> q_o == {WIDTH{LATCH_RESET_VALUE}})
    else $error("clear did not force output low");

  preset_forces_high_a: assert property (@(posedge mclk_i)
    !clr && ctrl_i.preset |-> q_o == {WIDTH{LATCH_PRESET_VALUE}})
    else $error("preset did not force output high");

  open_follows_a: assert property (@(posedge mclk_i)
    (ctrl_i.gate ^ INV_GATE) && ctrl_i.enable && !srst_i
    && !chip_wide_clear_i && !ctrl_i.force_low && !ctrl_i.preset
    |-> q_o == d_i)
    else $error("open latch does not follow data");

  close_captures_a: assert property (@(posedge mclk_i)
    disable iff (srst_i)
    $past(open_gate) && !open_gate && !clr && !ctrl_i.preset
    |-> q_o == $past(d_i))
    else $error("closing gate lost the data");

  closed_holds_a: assert property (@(posedge mclk_i)
    disable iff (srst_i)
    !open_gate && !clr && !ctrl_i.preset ##1
    !open_gate && !clr && !ctrl_i.preset
    |-> $stable(q_o))
    else $error("closed latch changed output");

endmodule // latch_cell

// ==========================================================
// top: every variant of the family side by side
// ==========================================================
module latch_family (
  // clock, reset and common clear
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic chip_wide_clear_i,
  // basic latches
  input wire logic basic_gate_i,
  input wire logic basic_d_i,
  output logic basic_q_o,
  input wire logic basic_x4_gate_i,
  input wire logic [latch_family_pkg::NARROW_WIDTH-1:0] basic_x4_d_i,
  output logic [latch_family_pkg::NARROW_WIDTH-1:0] basic_x4_q_o,
  input wire logic basic_x8_gate_i,
  input wire logic [latch_family_pkg::MID_WIDTH-1:0] basic_x8_d_i,
  output logic [latch_family_pkg::MID_WIDTH-1:0] basic_x8_q_o,
  input wire logic basic_x16_gate_i,
  input wire logic [latch_family_pkg::WIDE_WIDTH-1:0] basic_x16_d_i,
  output logic [latch_family_pkg::WIDE_WIDTH-1:0] basic_x16_q_o,
  // inverted-gate latch
  input wire logic inv_gate_i,
  input wire logic inv_d_i,
  output logic inv_q_o,
  // clearable latches
  input wire latch_family_pkg::latch_ctrl_t clr_ctrl_i,
  input wire logic clr_d_i,
  output logic clr_q_o,
  input wire latch_family_pkg::latch_ctrl_t clr_inv_ctrl_i,
  input wire logic clr_inv_d_i,
  output logic clr_inv_q_o,
  // enabled clearable latches
  input wire latch_family_pkg::latch_ctrl_t en_x4_ctrl_i,
  input wire logic [latch_family_pkg::NARROW_WIDTH-1:0] en_x4_d_i,
  output logic [latch_family_pkg::NARROW_WIDTH-1:0] en_x4_q_o,
  input wire latch_family_pkg::latch_ctrl_t en_x8_ctrl_i,
  input wire logic [latch_family_pkg::MID_WIDTH-1:0] en_x8_d_i,
  output logic [latch_family_pkg::MID_WIDTH-1:0] en_x8_q_o,
  input wire latch_family_pkg::latch_ctrl_t en_x16_ctrl_i,
  input wire logic [latch_family_pkg::WIDE_WIDTH-1:0] en_x16_d_i,
  output logic [latch_family_pkg::WIDE_WIDTH-1:0] en_x16_q_o,
  // clear and preset latches
  input wire latch_family_pkg::latch_ctrl_t cp_ctrl_i,
  input wire logic cp_d_i,
  output logic cp_q_o,
  input wire latch_family_pkg::latch_ctrl_t cpe_ctrl_i,
  input wire logic cpe_d_i,
  output logic cpe_q_o
);
  import latch_family_pkg::*;

  // unused fields of each variant are pinned so that they cannot act
  latch_ctrl_t c_basic, c_x4, c_x8, c_x16, c_inv;
  latch_ctrl_t c_clr, c_clr_inv, c_en4, c_en8, c_en16, c_cp, c_cpe;

  assign c_basic = '{gate: basic_gate_i, enable: 1'h1,
                     force_low: 1'h0, preset: 1'h0};
  assign c_x4 = '{gate: basic_x4_gate_i, enable: 1'h1,
                  force_low: 1'h0, preset: 1'h0};
  assign c_x8 = '{gate: basic_x8_gate_i, enable: 1'h1,
                  force_low: 1'h0, preset: 1'h0};
  assign c_x16 = '{gate: basic_x16_gate_i, enable: 1'h1,
                   force_low: 1'h0, preset: 1'h0};
  assign c_inv = '{gate: inv_gate_i, enable: 1'h1,
                   force_low: 1'h0, preset: 1'h0};
  assign c_clr = '{gate: clr_ctrl_i.gate, enable: 1'h1,
                   force_low: clr_ctrl_i.force_low, preset: 1'h0};
  assign c_clr_inv = '{gate: clr_inv_ctrl_i.gate, enable: 1'h1,
                       force_low: clr_inv_ctrl_i.force_low,
                       preset: 1'h0};
  assign c_en4 = '{gate: en_x4_ctrl_i.gate, enable: en_x4_ctrl_i.enable,
                   force_low: en_x4_ctrl_i.force_low, preset: 1'h0};
  assign c_en8 = '{gate: en_x8_ctrl_i.gate, enable: en_x8_ctrl_i.enable,
                   force_low: en_x8_ctrl_i.force_low, preset: 1'h0};
  assign c_en16 = '{gate: en_x16_ctrl_i.gate,
                    enable: en_x16_ctrl_i.enable,
                    force_low: en_x16_ctrl_i.force_low,
                    preset: 1'h0};
  assign c_cp = '{gate: cp_ctrl_i.gate, enable: 1'h1,
                  force_low: cp_ctrl_i.force_low,
                  preset: cp_ctrl_i.preset};
  assign c_cpe = cpe_ctrl_i;

  // ==========================================================
  // instances
  // ==========================================================
  latch_cell #(.WIDTH(1), .INV_GATE(1'b0)) u_basic (.mclk_i(mclk_i),
    .srst_i(srst_i), .chip_wide_clear_i(chip_wide_clear_i),
    .ctrl_i(c_basic), .d_i(basic_d_i), .q_o(basic_q_o));
  latch_cell #(.WIDTH(NARROW_WIDTH), .INV_GATE(1'b0)) u_x4 (.mclk_i(mclk_i),
    .srst_i(srst_i), .chip_wide_clear_i(chip_wide_clear_i),
    .ctrl_i(c_x4), .d_i(basic_x4_d_i), .q_o(basic_x4_q_o));
  latch_cell #(.WIDTH(MID_WIDTH), .INV_GATE(1'b0)) u_x8 (.mclk_i(mclk_i),
    .srst_i(srst_i), .chip_wide_clear_i(chip_wide_clear_i),
    .ctrl_i(c_x8), .d_i(basic_x8_d_i), .q_o(basic_x8_q_o));
  latch_cell #(.WIDTH(WIDE_WIDTH), .INV_GATE(1'b0)) u_x16 (.mclk_i(mclk_i),
    .srst_i(srst_i), .chip_wide_clear_i(chip_wide_clear_i),
    .ctrl_i(c_x16), .d_i(basic_x16_d_i), .q_o(basic_x16_q_o));
  latch_cell #(.WIDTH(1), .INV_GATE(1'b1)) u_inv (.mclk_i(mclk_i),
    .srst_i(srst_i), .chip_wide_clear_i(chip_wide_clear_i),
    .ctrl_i(c_inv), .d_i(inv_d_i), .q_o(inv_q_o));
  latch_cell #(.WIDTH(1), .INV_GATE(1'b0)) u_clr (.mclk_i(mclk_i),
    .srst_i(srst_i), .chip_wide_clear_i(chip_wide_clear_i),
    .ctrl_i(c_clr), .d_i(clr_d_i), .q_o(clr_q_o));
  latch_cell #(.WIDTH(1), .INV_GATE(1'b1)) u_clr_inv (.mclk_i(mclk_i),
    .srst_i(srst_i), .chip_wide_clear_i(chip_wide_clear_i),
    .ctrl_i(c_clr_inv), .d_i(clr_inv_d_i), .q_o(clr_inv_q_o));
  latch_cell #(.WIDTH(NARROW_WIDTH), .INV_GATE(1'b0)) u_en4 (.mclk_i(mclk_i),
    .srst_i(srst_i), .chip_wide_clear_i(chip_wide_clear_i),
    .ctrl_i(c_en4), .d_i(en_x4_d_i), .q_o(en_x4_q_o));
  latch_cell #(.WIDTH(MID_WIDTH), .INV_GATE(1'b0)) u_en8 (.mclk_i(mclk_i),
    .srst_i(srst_i), .chip_wide_clear_i(chip_wide_clear_i),
    .ctrl_i(c_en8), .d_i(en_x8_d_i), .q_o(en_x8_q_o));
  latch_cell #(.WIDTH(WIDE_WIDTH), .INV_GATE(1'b0)) u_en16 (.mclk_i(mclk_i),
    .srst_i(srst_i), .chip_wide_clear_i(chip_wide_clear_i),
    .ctrl_i(c_en16), .d_i(en_x16_d_i), .q_o(en_x16_q_o));
  latch_cell #(.WIDTH(1), .INV_GATE(1'b0)) u_cp (.mclk_i(mclk_i),
    .srst_i(srst_i), .chip_wide_clear_i(chip_wide_clear_i),
    .ctrl_i(c_cp), .d_i(cp_d_i), .q_o(cp_q_o));
  latch_cell #(.WIDTH(1), .INV_GATE(1'b0)) u_cpe (.mclk_i(mclk_i),
    .srst_i(srst_i), .chip_wide_clear_i(chip_wide_clear_i),
    .ctrl_i(c_cpe), .d_i(cpe_d_i), .q_o(cpe_q_o));

  // ==========================================================
  // checks
  // ==========================================================
  reset_all_low_a: assert property (@(posedge mclk_i)
    srst_i || chip_wide_clear_i |-> basic_q_o == 1'h0 && inv_q_o == 1'h0
    && basic_x16_q_o == '0 && en_x16_q_o == '0 && cpe_q_o == 1'h0)
    else $error("reset or common clear left an output high");

  inv_low_follows_a: assert property (@(posedge mclk_i)
    !srst_i && !chip_wide_clear_i && !inv_gate_i |-> inv_q_o == inv_d_i)
    else $error("inverted latch not transparent with gate low");

  clr_inv_open_a: assert property (@(posedge mclk_i)
    !srst_i && !chip_wide_clear_i && !clr_inv_ctrl_i.gate
    && !clr_inv_ctrl_i.force_low |-> clr_inv_q_o == clr_inv_d_i)
    else $error("clearable inverted latch not transparent");

  enable_low_holds_a: assert property (@(posedge mclk_i)
    disable iff (srst_i || chip_wide_clear_i)
    !en_x8_ctrl_i.enable && !en_x8_ctrl_i.force_low
    ##1 !en_x8_ctrl_i.enable && !en_x8_ctrl_i.force_low
    |-> $stable(en_x8_q_o))
    else $error("enabled latch changed with enable low");

  shared_gate_a: assert property (@(posedge mclk_i)
    !srst_i && !chip_wide_clear_i && basic_x16_gate_i
    |-> basic_x16_q_o == basic_x16_d_i)
    else $error("wide latch bits do not follow shared gate");

  clear_beats_preset_a: assert property (@(posedge mclk_i)
    cpe_ctrl_i.force_low && cpe_ctrl_i.preset |-> cpe_q_o == 1'h0)
    else $error("preset beat clear");

endmodule // latch_family

`default_nettype wire

//--- verif/user_logic_model.sv
// user logic model driving the wide basic latch's gate and data
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// user logic model
// ==========================================================
module user_logic_model (
  // clock
  input wire logic mclk_i,
  // requests
  input wire logic open_i,
  input wire logic [15:0] word_i,
  // latch side
  output logic gate_o,
  output logic [15:0] d_o
);
  logic tog_q = 1'b0;

  // data moves every cycle while closed, so a held value is really tested
  always_ff @(posedge mclk_i) begin
    tog_q <= ~tog_q;
  end

  assign gate_o = open_i;
  assign d_o = open_i ? word_i : (~word_i ^ {16{tog_q}});
endmodule // user_logic_model

`default_nettype wire

//--- verif/transparent_latch_family_tb.sv
// self-checking testbench for the latch family
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// testbench top
// ==========================================================
module transparent_latch_family_tb;
  import latch_family_pkg::*;
  logic mclk_i = 1'b0, srst_i = 1'b1, chip_wide_clear_i = 1'b0;
  logic basic_gate_i = 1'b0, basic_d_i = 1'b0, basic_q_o;
  logic g4 = 1'b0, g8 = 1'b0, g16, open = 1'b0;
  logic [3:0] d4 = 4'h0, q4, e4d = 4'h0, e4q;
  logic [7:0] d8 = 8'h0, q8, e8d = 8'h0, e8q;
  logic [15:0] d16, q16, word = 16'h0, e16d = 16'h0, e16q;
  logic inv_gate_i = 1'b0, inv_d_i = 1'b0, inv_q_o;
  logic clr_d = 1'b0, clr_q, ci_d = 1'b0, ci_q, cp_d = 1'b0, cp_q;
  logic cpe_d = 1'b0, cpe_q;
  latch_ctrl_t clr_c = 4'h0, ci_c = 4'h0, cp_c = 4'h0, cpe_c = 4'h0;
  latch_ctrl_t en_c = 4'h0;
  int failures = 0, num_checks = 0;

  always #4 mclk_i = ~mclk_i;

  user_logic_model partner (.mclk_i(mclk_i), .open_i(open), .word_i(word),
    .gate_o(g16), .d_o(d16));

  latch_family dut (.mclk_i(mclk_i), .srst_i(srst_i),
    .chip_wide_clear_i(chip_wide_clear_i), .basic_gate_i(basic_gate_i),
    .basic_d_i(basic_d_i), .basic_q_o(basic_q_o), .basic_x4_gate_i(g4),
    .basic_x4_d_i(d4), .basic_x4_q_o(q4), .basic_x8_gate_i(g8),
    .basic_x8_d_i(d8), .basic_x8_q_o(q8), .basic_x16_gate_i(g16),
    .basic_x16_d_i(d16), .basic_x16_q_o(q16), .inv_gate_i(inv_gate_i),
    .inv_d_i(inv_d_i), .inv_q_o(inv_q_o), .clr_ctrl_i(clr_c),
    .clr_d_i(clr_d), .clr_q_o(clr_q), .clr_inv_ctrl_i(ci_c),
    .clr_inv_d_i(ci_d), .clr_inv_q_o(ci_q), .en_x4_ctrl_i(en_c),
    .en_x4_d_i(e4d), .en_x4_q_o(e4q), .en_x8_ctrl_i(en_c),
    .en_x8_d_i(e8d), .en_x8_q_o(e8q), .en_x16_ctrl_i(en_c),
    .en_x16_d_i(e16d), .en_x16_q_o(e16q), .cp_ctrl_i(cp_c), .cp_d_i(cp_d),
    .cp_q_o(cp_q), .cpe_ctrl_i(cpe_c), .cpe_d_i(cpe_d), .cpe_q_o(cpe_q));

  // ==========================================================
  // helpers
  // ==========================================================
  task automatic check(input string name, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // inputs change on the falling edge, outputs are read 1 ns later
  task automatic tick();
    @(negedge mclk_i);
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  // ==========================================================
  task automatic t_reset();
    basic_gate_i = 1'b1; basic_d_i = 1'b1;
    repeat (8) tick();
    #1 check("basic in reset", basic_q_o, 16'h0);
    basic_gate_i = 1'b0;
    tick(); srst_i = 1'b0;
    #1 check("basic after reset", basic_q_o, 16'h0);
  endtask

  task automatic t_basic();
    tick(); basic_gate_i = 1'b1; basic_d_i = 1'b1; g4 = 1'b1; d4 = 4'ha;
    g8 = 1'b1; d8 = 8'h5a; open = 1'b1; word = 16'hc3a5;
    #1 check("basic open", basic_q_o, 16'h1);
    check("x16 open", q16, 16'hc3a5);
    tick(); basic_gate_i = 1'b0; basic_d_i = 1'b0; g4 = 1'b0; d4 = 4'h5;
    g8 = 1'b0; d8 = 8'ha5; open = 1'b0;
    repeat (2) begin
      #1 check("basic held", basic_q_o, 16'h1);
      check("x4 held", q4, 16'ha);
      check("x8 held", q8, 16'h5a);
      check("x16 held", q16, 16'hc3a5);
      tick();
    end
  endtask

  task automatic t_inv();
    tick(); inv_gate_i = 1'b0; inv_d_i = 1'b1;
    #1 check("inv open", inv_q_o, 16'h1);
    tick(); inv_gate_i = 1'b1; inv_d_i = 1'b0;
    #1 check("inv held", inv_q_o, 16'h1);
    tick(); #1 check("inv still held", inv_q_o, 16'h1);
  endtask

  task automatic t_clear();
    tick(); clr_c = 4'h8; clr_d = 1'b1; ci_c = 4'h0; ci_d = 1'b1;
    #1 check("clr open", clr_q, 16'h1);
    check("clr_inv open", ci_q, 16'h1);
    tick(); clr_c = 4'ha; ci_c = 4'h2;
    #1 check("clr forced", clr_q, 16'h0);
    check("clr_inv forced", ci_q, 16'h0);
    tick(); clr_c = 4'h0; ci_c = 4'h8;
    #1 check("clr kept low", clr_q, 16'h0);
    check("clr_inv kept low", ci_q, 16'h0);
    tick(); ci_c = 4'h0;
    tick(); ci_c = 4'h8; ci_d = 1'b0;
    #1 check("clr_inv captured", ci_q, 16'h1);
  endtask

  task automatic t_preset();
    tick(); cp_c = 4'hb; cp_d = 1'b1; cpe_c = 4'hf; cpe_d = 1'b1;
    #1 check("cp clear wins", cp_q, 16'h0);
    check("cpe clear wins", cpe_q, 16'h0);
    tick(); cp_c = 4'h1; cp_d = 1'b0; cpe_c = 4'hd; cpe_d = 1'b0;
    #1 check("cp preset", cp_q, 16'h1);
    check("cpe preset", cpe_q, 16'h1);
    tick(); cp_c = 4'h0; cpe_c = 4'h8;
    #1 check("cp held", cp_q, 16'h1);
    check("cpe no enable", cpe_q, 16'h1);
    tick(); cp_c = 4'h8; cpe_c = 4'hc;
    #1 check("cp open", cp_q, 16'h0);
    check("cpe open", cpe_q, 16'h0);
  endtask

  task automatic t_enable();
    tick(); en_c = 4'h8; e4d = 4'hf; e8d = 8'hff; e16d = 16'hffff;
    #1 check("x4 disabled", e4q, 16'h0);
    tick(); en_c = 4'hc; e4d = 4'h6; e8d = 8'h3c; e16d = 16'h9a5c;
    #1 check("x4 open", e4q, 16'h6);
    tick(); en_c = 4'h4; e4d = 4'h9; e8d = 8'hc3; e16d = 16'h65a3;
    #1 check("x4 held", e4q, 16'h6);
    check("x8 held", e8q, 16'h3c);
    check("x16 held", e16q, 16'h9a5c);
    tick(); en_c = 4'he;
    #1 check("x16 cleared", e16q, 16'h0);
  endtask

  task automatic t_global();
    tick(); basic_gate_i = 1'b1; basic_d_i = 1'b1; cp_c = 4'h1;
    chip_wide_clear_i = 1'b1;
    #1 check("basic cleared", basic_q_o, 16'h0);
    check("cp cleared", cp_q, 16'h0);
    tick(); chip_wide_clear_i = 1'b0; basic_gate_i = 1'b0; cp_c = 4'h0;
    #1 check("basic stays low", basic_q_o, 16'h0);
  endtask

  // generous bound: the scenarios need well under 100 cycles
  initial begin
    repeat (2000) @(posedge mclk_i);
    failures++;
    wrap_up();
  end

  initial begin
    t_reset();
    t_basic();
    t_inv();
    t_clear();
    t_preset();
    t_enable();
    t_global();
    wrap_up();
  end
endmodule // transparent_latch_family_tb

`default_nettype wire
